// >>> stc_asserts.sv
// Output checker for the sweep trigger controller.
// Sees only stc_top ports; bound from the testbench top file.
`timescale 1ns/1ps
module stc_asserts (
	input wire hclk,
	input wire hresetn,
	input wire hreadyout,
	input wire hresp,
	input wire sweep_done,
	input wire sweep_start,
	input wire sweep_active,
	input wire trig_waiting
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_bus_ready: assert property (hreadyout)
		else $error("hreadyout low");
	a_resp_okay: assert property (!hresp)
		else $error("hresp not okay");
	a_start_active: assert property (sweep_start |=> sweep_active)
		else $error("start without active sweep");
	a_active_cause: assert property ($rose(sweep_active) |->
		sweep_start || $past(sweep_start)) else $error("sweep with no start");
	a_busy_no_start: assert property
		(sweep_active && !sweep_done |=> !sweep_start)
		else $error("start during sweep");
	a_active_holds: assert property
		(sweep_active && !sweep_done |=> sweep_active)
		else $error("sweep ended early");
	a_done_ends: assert property (sweep_active && sweep_done |=>
		!sweep_active) else $error("sweep outlived done");
	a_wait_idle: assert property (sweep_active |-> !trig_waiting)
		else $error("waiting during sweep");
	c_start: cover property (sweep_start);
	c_armed: cover property ($fell(trig_waiting));
	c_done: cover property (sweep_active && sweep_done);
endmodule

// >>> stc_map.vh
// Register map, field positions, reset values and timing constants of the
// sweep trigger controller. Definitions only; included by stc_top.v.
`ifndef STC_MAP_VH
`define STC_MAP_VH

`define STC_OFS_CTRL      8'h00
`define STC_OFS_CMD       8'h04
`define STC_OFS_PERIOD    8'h08
`define STC_OFS_OFFSET    8'h0C
`define STC_OFS_DELAY     8'h10
`define STC_OFS_HOLDOFF   8'h14
`define STC_OFS_AUTO      8'h18
`define STC_OFS_LEVEL     8'h1C
`define STC_OFS_STATUS    8'h20
`define STC_OFS_CLIP      8'h24
`define STC_OFS_GAINMAX   8'h28

// CTRL fields
`define STC_CTRL_SRC_LSB  0
`define STC_CTRL_SLOPE    3
`define STC_CTRL_CONT     4
`define STC_CTRL_HOFF_EN  5
`define STC_CTRL_MEAS_LSB 6
`define STC_CTRL_RESET    32'h0000_0020

// CMD bits (write-one pulses)
`define STC_CMD_SINGLE    0
`define STC_CMD_RUNHOLD   1
`define STC_CMD_RSTOFS    2

// Trigger sources
`define STC_SRC_FREE      3'h0
`define STC_SRC_EXT       3'h1
`define STC_SRC_PERIODIC  3'h2
`define STC_SRC_VIDEO     3'h3
`define STC_SRC_IFBURST   3'h4

// Measurement types
`define STC_MEAS_DENSITY  2'h0
`define STC_MEAS_SPGRAM   2'h1
`define STC_MEAS_RTSPEC   2'h2

// Times in their own units, and cycle counts at 40 MHz
`define STC_CLK_HZ        40000000
`define STC_PERIOD_MIN_NS 100
`define STC_PERIOD_MAX_MS 400
`define STC_OFFSET_MAX_MS 100
`define STC_DELAY_MAX_S   10
`define STC_HOLD_MAX_S    10
`define STC_AUTO_MIN_MS   1
`define STC_AUTO_MAX_S    100
`define STC_PERIOD_MIN_CYC ((`STC_PERIOD_MIN_NS * 40 + 999) / 1000)
`define STC_PERIOD_MAX_CYC (`STC_PERIOD_MAX_MS * 40000)
`define STC_OFFSET_MAX_CYC (`STC_OFFSET_MAX_MS * 40000)
`define STC_DELAY_MAX_CYC  (`STC_DELAY_MAX_S * `STC_CLK_HZ)
`define STC_HOLD_MAX_CYC   (`STC_HOLD_MAX_S * `STC_CLK_HZ)
`define STC_AUTO_MIN_CYC   (`STC_AUTO_MIN_MS * 40000)
`define STC_AUTO_MAX_CYC   (32'd100 * `STC_CLK_HZ)

// Trigger level in dBm, signed
`define STC_LEVEL_MIN     -210
`define STC_LEVEL_MAX     30
`define STC_LEVEL_RESET   16'hFFDD
`define STC_GAINMAX_RESET 16'h001E

`endif

// >>> stc_partner.sv
// Far side: trigger pin, level samples and a sweep engine.
// Driven by tb at rising edges; each sweep lasts slen cycles.
`timescale 1ns/1ps
module stc_partner (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        sweep_start,
	input  wire        ext_set,
	input  wire [15:0] sig_set,
	input  wire [7:0]  slen,
	output reg         ext_trig_in,
	output reg  [15:0] video_sample,
	output reg  [15:0] if_burst_det,
	output reg         sweep_done
);
	reg [7:0] cnt_q;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q        <= 8'h0;
			sweep_done   <= 1'b0;
			ext_trig_in  <= 1'b0;
			video_sample <= 16'h8000;
			if_burst_det <= 16'h8000;
		end else begin
			ext_trig_in  <= ext_set;
			video_sample <= sig_set;
			// Detector lags a cycle, as a real IF path would
			if_burst_det <= video_sample;
			sweep_done   <= (cnt_q == 8'h1);
			if (sweep_start)
				cnt_q <= slen;
			else if (cnt_q != 8'h0)
				cnt_q <= cnt_q - 8'h1;
		end
	end
endmodule

// >>> stc_top.v
// Sweep trigger controller: picks the trigger source, qualifies edges,
// applies delay, hold-off and auto-trigger, and issues sweep starts.
// Assumes an AHB-Lite master on hclk, a sweep engine that answers each
// sweep_start with a sweep_done pulse, and level samples already in dBm.
`timescale 1ns/1ps
`include "stc_map.vh"

module stc_top (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	input  wire        ext_trig_in,
	input  wire [15:0] video_sample,
	input  wire [15:0] if_burst_det,
	input  wire        sweep_done,
	output reg         sweep_start,
	output reg         sweep_active,
	output reg         trig_waiting
);

	localparam ST_IDLE  = 4'b0001;
	localparam ST_ARMED = 4'b0010;
	localparam ST_DELAY = 4'b0100;
	localparam ST_SWEEP = 4'b1000;

	reg [31:0] ctrl_q;
	reg [31:0] period_q;
	reg [31:0] offset_q;
	reg [31:0] delay_q;
	reg [31:0] holdoff_q;
	reg [31:0] auto_q;
	reg [15:0] level_q;
	reg [15:0] gainmax_q;
	reg        clip_err_q;
	reg [15:0] clip_amt_q;
	reg        run_q;
	reg        once_q;
	reg [3:0]  state_q;
	reg [31:0] dly_cnt_q;
	reg [31:0] hold_cnt_q;
	reg [31:0] auto_cnt_q;
	reg [31:0] per_cnt_q;
	reg        per_ev_q;
	reg [1:0]  ext_sync_q;
	reg        ap_wr_q;
	reg        ap_rd_q;
	reg [7:0]  ap_addr_q;

	wire [2:0] src   = ctrl_q[`STC_CTRL_SRC_LSB +: 3];
	wire       slope = ctrl_q[`STC_CTRL_SLOPE];
	wire       cont  = ctrl_q[`STC_CTRL_CONT];
	wire       hoff_en = ctrl_q[`STC_CTRL_HOFF_EN];
	wire [1:0] meas  = ctrl_q[`STC_CTRL_MEAS_LSB +: 2];

	// Bus address phase
	// Only whole-word transfers are decoded; narrower ones are dropped
	// rather than half-written into a 32-bit time register
	wire ap_valid = hsel & hready & htrans[1] & (hsize == 3'h2);
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	wire wr_en = ap_wr_q;
	wire cmd_wr = wr_en & (ap_addr_q == `STC_OFS_CMD);
	wire cmd_single  = cmd_wr & hwdata[`STC_CMD_SINGLE];
	wire cmd_runhold = cmd_wr & hwdata[`STC_CMD_RUNHOLD];
	wire cmd_rstofs  = cmd_wr & hwdata[`STC_CMD_RSTOFS];

	// Effective video level: clipped to what the gain setup reaches
	wire signed [15:0] lvl_s  = level_q;
	wire signed [15:0] gmax_s = gainmax_q;
	wire vid_clip = lvl_s > gmax_s;
	wire signed [15:0] vid_lvl = vid_clip ? gmax_s : lvl_s;
	// Clip distance in dB, meaningful while the level exceeds the limit
	wire        [15:0] clip_diff = lvl_s - gmax_s;

	// Level comparators; samples are same-domain data
	wire vid_above = $signed(video_sample) >= vid_lvl;
	wire ifb_above = $signed(if_burst_det) >= lvl_s;
	wire ext_lvl   = ext_sync_q[1];

	// One edge qualifier per level source: bit 0 pin, 1 video, 2 IF
	wire [2:0] lvl_now = {ifb_above, vid_above, ext_lvl};
	reg  [2:0] lvl_prev_q;
	wire [2:0] lvl_edge;
	genvar     gi;

	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_edge
			// Slope selects the qualifying direction; 0 = rising
			assign lvl_edge[gi] = slope ? (lvl_prev_q[gi] & ~lvl_now[gi])
				: (~lvl_prev_q[gi] & lvl_now[gi]);
			// Cleared at reset to the idle level, so no false edge follows
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn)
					lvl_prev_q[gi] <= 1'b0;
				else
					lvl_prev_q[gi] <= lvl_now[gi];
			end
		end
	endgenerate

	wire ext_edge = lvl_edge[0];
	wire vid_edge = lvl_edge[1];
	wire ifb_edge = lvl_edge[2];

	reg trig_ev;
	always @* begin
		case (src)
		`STC_SRC_FREE:     trig_ev = 1'b1;
		`STC_SRC_EXT:      trig_ev = ext_edge;
		`STC_SRC_PERIODIC: trig_ev = per_ev_q;
		`STC_SRC_VIDEO:    trig_ev = vid_edge;
		`STC_SRC_IFBURST:  trig_ev = ifb_edge;
		default:           trig_ev = 1'b0;
		endcase
	end

	// Programmed times saturate at their upper range limits
	wire [31:0] dly_lim  = (delay_q > `STC_DELAY_MAX_CYC) ?
		`STC_DELAY_MAX_CYC : delay_q;
	wire [31:0] hold_lim = (holdoff_q > `STC_HOLD_MAX_CYC) ?
		`STC_HOLD_MAX_CYC : holdoff_q;
	wire [31:0] auto_lim = (auto_q > `STC_AUTO_MAX_CYC) ?
		`STC_AUTO_MAX_CYC : auto_q;

	// Spectrogram runs untriggered, as does free run
	wire gated = (meas != `STC_MEAS_SPGRAM);
	// Hold-off guards only the pin and level sources
	wire uses_hold = gated & (src == `STC_SRC_EXT | src == `STC_SRC_VIDEO
		| src == `STC_SRC_IFBURST);
	wire hold_busy = uses_hold & hoff_en & (hold_cnt_q != 32'h0);
	wire accept = (state_q == ST_ARMED) & (~gated | (trig_ev & ~hold_busy));
	wire auto_fire = (state_q == ST_ARMED) & gated & (auto_q != 32'h0)
		& (auto_cnt_q >= auto_lim - 32'h1) & ~accept;
	wire go = accept | auto_fire;

	// Periodic grid: phase counter starts at zero; the event falls at the signed offset, modulo period
	wire [31:0] per_len = (period_q < `STC_PERIOD_MIN_CYC) ?
		`STC_PERIOD_MIN_CYC : (period_q > `STC_PERIOD_MAX_CYC) ?
		`STC_PERIOD_MAX_CYC : period_q;
	wire signed [31:0] ofs_s   = offset_q;
	wire signed [31:0] ofs_max = `STC_OFFSET_MAX_CYC;
	// Offset saturates at plus or minus its range, then folds into the grid
	wire [31:0] ofs_lim = (ofs_s > ofs_max) ? ofs_max
		: (ofs_s < -ofs_max) ? -ofs_max : offset_q;
	wire [31:0] per_phase = ofs_lim[31] ? (per_len + ofs_lim) : ofs_lim;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_q   <= 1'b0;
			ap_rd_q   <= 1'b0;
			ap_addr_q <= 8'h00;
		end else begin
			ap_wr_q   <= ap_valid & hwrite;
			ap_rd_q   <= ap_valid & ~hwrite;
			ap_addr_q <= haddr[7:0];
		end
	end

	// Register writes in data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q    <= `STC_CTRL_RESET;
			period_q  <= 32'h0000_0004;
			offset_q  <= 32'h0;
			delay_q   <= 32'h0;
			holdoff_q <= 32'h0;
			auto_q    <= 32'h0;
			level_q   <= `STC_LEVEL_RESET;
			gainmax_q <= `STC_GAINMAX_RESET;
		end else begin
			if (wr_en) begin
				case (ap_addr_q)
				`STC_OFS_CTRL:    ctrl_q    <= {24'h0, hwdata[7:0]};
				`STC_OFS_PERIOD:  period_q  <= hwdata;
				`STC_OFS_OFFSET:  offset_q  <= hwdata;
				`STC_OFS_DELAY:   delay_q   <= hwdata;
				`STC_OFS_HOLDOFF: holdoff_q <= hwdata;
				`STC_OFS_AUTO:    auto_q    <= hwdata;
				`STC_OFS_LEVEL:   level_q   <= hwdata[15:0];
				`STC_OFS_GAINMAX: gainmax_q <= hwdata[15:0];
				default: ;
				endcase
			end
			if (cmd_rstofs)
				offset_q <= 32'h0;
		end
	end

	// Clip error: sticky; a new clip wins over a software clear
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clip_err_q <= 1'b0;
			clip_amt_q <= 16'h0;
		end else begin
			clip_amt_q <= vid_clip ? clip_diff : 16'h0;
			if (vid_clip & (src == `STC_SRC_VIDEO))
				clip_err_q <= 1'b1;
			else if (wr_en & (ap_addr_q == `STC_OFS_CLIP) & hwdata[0])
				clip_err_q <= 1'b0;
		end
	end

	// Status word: run, hold-off busy, waiting, active, delay, armed
	wire [5:0] status_w = {run_q, hold_busy, trig_waiting, sweep_active,
		state_q[2], state_q[1]};

	// Read data is taken in the address phase so it stands all data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
		end else if (ap_valid & ~hwrite) begin
			case (haddr[7:0])
			`STC_OFS_CTRL:    hrdata <= ctrl_q;
			`STC_OFS_PERIOD:  hrdata <= period_q;
			`STC_OFS_OFFSET:  hrdata <= offset_q;
			`STC_OFS_DELAY:   hrdata <= delay_q;
			`STC_OFS_HOLDOFF: hrdata <= holdoff_q;
			`STC_OFS_AUTO:    hrdata <= auto_q;
			`STC_OFS_LEVEL:   hrdata <= {{16{level_q[15]}}, level_q};
			`STC_OFS_GAINMAX: hrdata <= {{16{gainmax_q[15]}}, gainmax_q};
			`STC_OFS_STATUS:  hrdata <= {26'h0, status_w};
			`STC_OFS_CLIP:    hrdata <= {clip_amt_q, 15'h0, clip_err_q};
			default:          hrdata <= 32'h0;
			endcase
		end
	end

	// Input capture: the pin passes two flops before any logic
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_sync_q <= 2'b00;
		end else begin
			ext_sync_q <= {ext_sync_q[0], ext_trig_in};
		end
	end

	// Periodic generator; offset write or reset restarts the phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			per_cnt_q <= 32'h0;
			per_ev_q  <= 1'b0;
		end else begin
			per_ev_q <= 1'b0;
			if (cmd_rstofs | (wr_en & (ap_addr_q == `STC_OFS_OFFSET
				| ap_addr_q == `STC_OFS_PERIOD))) begin
				per_cnt_q <= 32'h0;
			end else if (per_cnt_q >= per_len - 32'h1) begin
				per_cnt_q <= 32'h0;
			end else begin
				per_cnt_q <= per_cnt_q + 32'h1;
			end
			// One event per lap, where the counter meets the phase
			if (per_cnt_q == per_phase % per_len)
				per_ev_q <= 1'b1;
		end
	end

	// Run control: continuous toggles with run/hold; single does one sweep
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_q  <= 1'b0;
			once_q <= 1'b0;
		end else begin
			// Single always wins, even over a run/hold in the same write
			if (cmd_single) begin
				run_q  <= 1'b1;
				once_q <= 1'b1;
			end else if (cmd_runhold) begin
				once_q <= ~cont;
				run_q  <= cont ? ~run_q : 1'b1;
			end else if (once_q & sweep_done & (state_q == ST_SWEEP)) begin
				run_q  <= 1'b0;
				once_q <= 1'b0;
			end
		end
	end

	// Sequencer
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q      <= ST_IDLE;
			dly_cnt_q    <= 32'h0;
			auto_cnt_q   <= 32'h0;
			sweep_start  <= 1'b0;
			sweep_active <= 1'b0;
			trig_waiting <= 1'b0;
		end else begin
			sweep_start <= 1'b0;
			case (state_q)
			ST_IDLE: begin
				if (run_q & ~(once_q & ~cmd_single & sweep_active)) begin
					state_q    <= ST_ARMED;
					auto_cnt_q <= 32'h0;
				end
			end
			ST_ARMED: begin
				trig_waiting <= ~go & gated & (src != `STC_SRC_FREE);
				// Timer restarts on each entry, so a long sweep never eats it
				auto_cnt_q <= auto_cnt_q + 32'h1;
				if (~run_q) begin
					state_q      <= ST_IDLE;
					trig_waiting <= 1'b0;
				end else if (go) begin
					state_q   <= ST_DELAY;
					dly_cnt_q <= 32'h0;
				end
			end
			ST_DELAY: begin
				// Triggers in this state never reach accept
				if (~gated | dly_cnt_q >= dly_lim) begin
					state_q      <= ST_SWEEP;
					sweep_start  <= 1'b1;
					sweep_active <= 1'b1;
				end else begin
					dly_cnt_q <= dly_cnt_q + 32'h1;
				end
			end
			ST_SWEEP: begin
				if (sweep_done) begin
					sweep_active <= 1'b0;
					state_q      <= (cont & ~once_q) ? ST_ARMED : ST_IDLE;
					auto_cnt_q   <= 32'h0;
				end
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Hold-off runs from the accepted event, independent of the sweep
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_cnt_q <= 32'h0;
		end else if (accept & uses_hold & hoff_en) begin
			// Each accepted event restarts the window from itself
			hold_cnt_q <= hold_lim;
		end else if (hold_cnt_q != 32'h0) begin
			hold_cnt_q <= hold_cnt_q - 32'h1;
		end
	end

endmodule

// >>> tb.sv
// Self-checking bench for stc_top with its far-side model.
// Assumes zero-wait AHB-Lite slave and 40 MHz hclk.
`timescale 1ns/1ps
`include "stc_map.vh"
module tb;
	logic        hclk, hresetn, hsel, hwrite, ext_set;
	logic [1:0]  htrans;
	logic [2:0]  hsize, s;
	logic [31:0] haddr, hwdata, r;
	logic [15:0] sig_set;
	logic [7:0]  slen;
	wire         hreadyout, hresp, ext_trig_in, sweep_done;
	wire         sweep_start, sweep_active, trig_waiting;
	wire  [31:0] hrdata;
	wire  [15:0] video_sample, if_burst_det;
	integer      err_count, compares, seed, c, k, d;
	stc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .ext_trig_in(ext_trig_in),
		.video_sample(video_sample), .if_burst_det(if_burst_det),
		.sweep_done(sweep_done), .sweep_start(sweep_start),
		.sweep_active(sweep_active), .trig_waiting(trig_waiting));
	stc_partner u_far (.hclk(hclk), .hresetn(hresetn),
		.sweep_start(sweep_start), .ext_set(ext_set), .sig_set(sig_set),
		.slen(slen), .ext_trig_in(ext_trig_in),
		.video_sample(video_sample), .if_burst_det(if_burst_det),
		.sweep_done(sweep_done));
	initial begin
		hclk = 0;
		forever #12.5 hclk = ~hclk;
	end
	// Whole run is a few thousand cycles; this leaves ample margin
	initial begin
		#500000;
		err_count = err_count + 1;
		tally_and_finish;
	end
	task tally_and_finish;
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp, input string nm);
		compares = compares + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("MISMATCH %s exp %h seen %h", nm, exp, got);
		end
	endtask
	function [31:0] ctl(input [2:0] src, input sl, co, ho, input [1:0] m);
		ctl = {24'h0, m, ho, co, sl, src};
	endfunction
	task bus(input w, input [7:0] a, input [31:0] dd);
		@(posedge hclk);
		hsel <= 1; htrans <= 2'h2; haddr <= {24'h0, a};
		hwrite <= w; hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 0; htrans <= 2'h0; hwdata <= dd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task wr(input [7:0] a, input [31:0] dd);
		bus(1, a, dd);
	endtask
	task rdc(input [7:0] a, input [31:0] m, e, input string nm);
		bus(0, a, 32'h0);
		chk(r & m, e, nm);
	endtask
	// Stops at the first start or after n cycles; c is the count
	task ws(input integer n);
		c = 0;
		do begin
			@(negedge hclk);
			c = c + 1;
		end while (c < n && sweep_start !== 1'b1);
	endtask
	task cnt(input integer n);
		k = 0;
		repeat (n) begin
			@(negedge hclk);
			if (sweep_start === 1'b1) k = k + 1;
		end
	endtask
	task pulse;
		@(posedge hclk) ext_set <= 1;
		repeat (4) @(posedge hclk);
		ext_set <= 0;
	endtask
	initial begin
		err_count = 0; compares = 0; seed = 32'he338ffc3;
		hresetn = 0; hsel = 0; hwrite = 0; htrans = 0; hsize = 0;
		haddr = 0; hwdata = 0; ext_set = 0; sig_set = 16'hFF9C;
		slen = 8'h3 + $unsigned($random(seed)) % 8;
		repeat (5) @(posedge hclk);
		hresetn <= 1;
		rdc(`STC_OFS_CTRL, 32'hFF, 32'h20, "ctrl");
		rdc(`STC_OFS_LEVEL, 32'hFFFF, 32'hFFDD, "level");
		rdc(`STC_OFS_GAINMAX, 32'hFFFF, 32'h1E, "gainmax");
		rdc(8'h30, 32'hFFFFFFFF, 32'h0, "unmapped");
		wr(`STC_OFS_OFFSET, 32'h123);
		wr(`STC_OFS_CMD, 32'h4);
		rdc(`STC_OFS_OFFSET, 32'hFFFFFFFF, 32'h0, "offset");
		wr(`STC_OFS_LEVEL, 32'hFFFFFF2E);
		rdc(`STC_OFS_LEVEL, 32'hFFFF, 32'hFF2E, "lvl min");
		wr(`STC_OFS_LEVEL, 32'hFFFFFFDD);
		wr(`STC_OFS_CTRL, ctl(0, 0, 1, 1, 0));
		wr(`STC_OFS_CMD, 32'h2);
		cnt(300);
		chk(k >= 3, 1, "free run");
		wr(`STC_OFS_CMD, 32'h2);
		cnt(40);
		cnt(100);
		chk(k, 0, "hold");
		for (s = 0; s < 2; s++) begin
			d = 5 + $unsigned($random(seed)) % 36;
			@(posedge hclk) ext_set <= (s == 0);
			wr(`STC_OFS_DELAY, d);
			wr(`STC_OFS_CTRL, ctl(1, s[0], 0, 1, 0));
			wr(`STC_OFS_CMD, 32'h1);
			repeat (4) @(negedge hclk);
			chk(trig_waiting, 1, "waiting");
			@(posedge hclk) ext_set <= (s != 0);
			ws(60);
			chk(sweep_start, 0, "wrong edge");
			@(posedge hclk) ext_set <= (s == 0);
			ws(d + 20);
			chk(sweep_start, 1, "ext start");
			chk(c >= d && c <= d + 10, 1, "delay");
			cnt(100);
			chk(k, 0, "single");
		end
		wr(`STC_OFS_DELAY, 32'h0);
		wr(`STC_OFS_AUTO, 32'd50);
		wr(`STC_OFS_CMD, 32'h1);
		ws(100);
		chk(c >= 45 && c <= 60, 1, "auto");
		wr(`STC_OFS_AUTO, 32'h0);
		cnt(40);
		for (s = 3; s < 5; s++) begin
			wr(`STC_OFS_CTRL, ctl(s, 0, 0, 1, 0));
			wr(`STC_OFS_CMD, 32'h1);
			ws(50);
			chk(sweep_start, 0, "below");
			@(posedge hclk) sig_set <= 16'h0;
			ws(50);
			chk(sweep_start, 1, "cross");
			cnt(40);
			@(posedge hclk) sig_set <= 16'hFF9C;
		end
		wr(`STC_OFS_CTRL, ctl(1, 0, 0, 1, 1));
		wr(`STC_OFS_CMD, 32'h1);
		ws(50);
		chk(sweep_start, 1, "spectrogram");
		cnt(40);
		wr(`STC_OFS_HOLDOFF, 32'd200);
		for (s = 0; s < 2; s++) begin
			wr(`STC_OFS_CTRL, ctl(1, 0, 1, !s[0], 0));
			wr(`STC_OFS_CMD, 32'h2);
			pulse;
			cnt(50);
			pulse;
			cnt(50);
			chk(k, s, "holdoff");
			wr(`STC_OFS_CMD, 32'h2);
			cnt(150);
		end
		wr(`STC_OFS_HOLDOFF, 32'h0);
		d = 20 + $unsigned($random(seed)) % 30;
		wr(`STC_OFS_PERIOD, d);
		wr(`STC_OFS_CTRL, ctl(2, 0, 1, 1, 0));
		wr(`STC_OFS_CMD, 32'h2);
		ws(200);
		ws(200);
		chk(c, d, "period");
		wr(`STC_OFS_CMD, 32'h2);
		cnt(60);
		wr(`STC_OFS_GAINMAX, 32'h0);
		wr(`STC_OFS_LEVEL, 32'h14);
		wr(`STC_OFS_CTRL, ctl(3, 0, 0, 1, 0));
		rdc(`STC_OFS_CLIP, 32'hFFFF0001, 32'h00140001, "clip");
		tally_and_finish;
	end
endmodule
bind stc_top stc_asserts u_chk (.hclk(hclk), .hresetn(hresetn),
	.hreadyout(hreadyout), .hresp(hresp), .sweep_done(sweep_done),
	.sweep_start(sweep_start), .sweep_active(sweep_active),
	.trig_waiting(trig_waiting));
